// [logic/frame_fifo.sv]
// small word buffer with valid/ready on both sides
// assumes DEPTH is a power of two; synchronous active low reset
`timescale 1ns/100ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic rst_b,
  stream_if.snk     fill,
  stream_if.src     drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign fill.ready  = count != (AW+1)'(DEPTH);
  assign drain.valid = count != '0;
  assign drain.data  = mem[rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bounds: assert property (@(posedge clk) disable iff (!rst_b)
    count == (AW+1)'(DEPTH) |=> !fill.ready || $past(pop))
    else $error("buffer ready while full");
endmodule : frame_fifo
`default_nettype wire

// [logic/serial_cfg_pkg.sv]
// constants for the serial port protocol configuration block
// assumes byte addressed register access from a 16-bit host frame
package serial_cfg_pkg;
  // register byte addresses
  localparam logic [7:0] IN_CTL_ADDR  = 8'h08;
  localparam logic [7:0] OUT_CTL_ADDR = 8'h0c;
  // field positions inside the 32-bit register images
  localparam int IN_SEL_LSB   = 0;
  localparam int OUT_MODE_LSB = 0;
  localparam int SRC_CLK_BIT  = 6;
  localparam int SEC_CFG_LSB  = 8;
  localparam int GP_LEVEL_BIT = 12;
  // reset values
  localparam logic [1:0] SEL_RST  = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic       SRC_RST  = 1'h0;
  localparam logic [1:0] SEC_RST  = 2'h0;
  localparam logic       GP_RST   = 1'h0;
  // host frame layout
  localparam int FRAME_W   = 16;
  localparam int WRITE_BIT = 15;
  localparam int ADDR_MSB  = 14;
  localparam int ADDR_LSB  = 8;
  // second output pin functions
  localparam logic [1:0] SEC_TRISTATE = 2'h0;
  localparam logic [1:0] SEC_ALARM    = 2'h1;
  localparam logic [1:0] SEC_GPO      = 2'h2;
  localparam logic [1:0] SEC_DUAL     = 2'h3;
  // output mode encodings
  localparam logic [1:0] OUT_MODE_SRCSYNC = 2'h3;
  // buffer depth between link and register file
  localparam int FIFO_DEPTH = 2;
endpackage : serial_cfg_pkg

// [logic/serial_port_protocol_config.sv]
// serial port protocol configuration: input and output protocol registers
// assumes a host frame of 16 bits under cs_b; sclk and osc_clk are async
`timescale 1ns/100ps
`default_nettype none
module serial_port_protocol_config #(
  parameter int FIFO_DEPTH = serial_cfg_pkg::FIFO_DEPTH
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic sclk,
  input  wire logic osc_clk,
  input  wire logic cs_b,
  input  wire logic serial_in,
  input  wire logic app_rst_b,
  input  wire logic reset_pin_app_select,
  input  wire logic alarm_in,
  output logic      first_serial_output,
  output logic      first_serial_output_oe_b,
  output logic      second_serial_output,
  output logic      second_serial_output_oe_b,
  output logic      srcsync_clk_out,
  output logic      clock_polarity,
  output logic      clock_phase
);
  localparam int FW = serial_cfg_pkg::FRAME_W;

  typedef enum logic {CMD_IDLE, CMD_WAIT} cmd_state_t;

  // configuration fields
  logic [1:0] in_sel;
  logic [1:0] out_mode;
  logic       src_clk;
  logic [1:0] sec_cfg;
  logic       gp_level;

  // resets
  logic app_s1;
  logic app_s2;
  logic por;
  logic app_rst;
  logic link_run;

  // link receive side
  logic          edge_sel;
  logic          samp_clk;
  logic [3:0]    rx_cnt;
  logic [FW-2:0] rx_sh;
  logic [FW-1:0] rx_word;
  logic          req_tgl;
  logic          ack_l1;
  logic          ack_l2;

  // core command side
  logic          req_c1;
  logic          req_c2;
  logic          ack_tgl;
  cmd_state_t    state;
  cmd_state_t    next_state;
  logic          take;
  logic          is_wr;
  logic [7:0]    cmd_addr;
  logic [7:0]    cmd_data;
  logic [31:0]   in_img;
  logic [31:0]   out_img;
  logic [31:0]   in_new;
  logic [31:0]   out_new;
  logic          wr_in;
  logic          wr_out;
  logic [7:0]    rd_data;
  logic          rsp_tgl;
  logic          rsp_a1;
  logic          rsp_a2;

  // link transmit side
  logic          src_sync;
  logic          tx_clk;
  logic          dual;
  logic          skip;
  logic [1:0]    cfg_t1;
  logic [1:0]    cfg_t2;
  logic [4:0]    tx_cnt;
  logic          tx_live;
  logic          out0;
  logic          out1;
  logic [4:0]    idx;
  logic [5:0]    pos0;
  logic [5:0]    pos1;
  logic [7:0]    tx_hold;
  logic          rsp_t1;
  logic          rsp_t2;
  logic          rsp_seen;

  stream_if #(.WIDTH(FW)) fill_s ();
  stream_if #(.WIDTH(FW)) drain_s ();

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction : hit

  function automatic logic [7:0] get_byte(input logic [31:0] img,
                                          input logic [1:0]  lane);
    return img[8*lane +: 8];
  endfunction : get_byte

  function automatic logic [31:0] put_byte(input logic [31:0] img,
                                           input logic [1:0]  lane,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = img;
    r[8*lane +: 8] = d;
    return r;
  endfunction : put_byte

  function automatic logic pick(input logic [FW-1:0] w,
                                input logic [5:0]    p);
    return (p[5:4] == 2'h0) && w[~p[3:0]];
  endfunction : pick

  // reset classes: pin acts as power-on or application reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      app_s1 <= 1'b1;
      app_s2 <= 1'b1;
    end else begin
      app_s1 <= app_rst_b;
      app_s2 <= app_s1;
    end
  end

  assign por     = !rst_b || (!app_s2 && !reset_pin_app_select);
  assign app_rst = !app_s2 && reset_pin_app_select;

  always_ff @(posedge core_clk) begin
    link_run <= !por;
  end

  // receive: sampling edge follows polarity xor phase
  assign edge_sel = in_sel[1] ^ in_sel[0];
  assign samp_clk = sclk ^ edge_sel;

  always_ff @(posedge samp_clk or posedge cs_b) begin
    if (cs_b) begin
      rx_cnt <= 4'h0;
      rx_sh  <= '0;
    end else begin
      rx_cnt <= rx_cnt + 4'h1;
      rx_sh  <= {rx_sh[FW-3:0], serial_in};
    end
  end

  always_ff @(posedge samp_clk or negedge link_run) begin
    if (!link_run) begin
      req_tgl <= 1'b0;
      ack_l1  <= 1'b0;
      ack_l2  <= 1'b0;
      rx_word <= '0;
    end else begin
      ack_l1 <= ack_tgl;
      ack_l2 <= ack_l1;
      if (rx_cnt == 4'hf && req_tgl == ack_l2) begin
        rx_word <= {rx_sh, serial_in};
        req_tgl <= ~req_tgl;
      end
    end
  end

  // frame request crossing into the core clock, then buffered
  always_ff @(posedge core_clk) begin
    if (por) begin
      req_c1 <= 1'b0;
      req_c2 <= 1'b0;
    end else begin
      req_c1 <= req_tgl;
      req_c2 <= req_c1;
    end
  end

  assign fill_s.valid = req_c2 != ack_tgl;
  assign fill_s.data  = rx_word;

  always_ff @(posedge core_clk) begin
    if (por) begin
      ack_tgl <= 1'b0;
    end else if (fill_s.valid && fill_s.ready) begin
      ack_tgl <= ~ack_tgl;
    end
  end

  frame_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (core_clk),
    .rst_b (!por),
    .fill  (fill_s),
    .drain (drain_s)
  );

  // command decode
  assign drain_s.ready = state == CMD_IDLE;
  assign take     = drain_s.valid && drain_s.ready;
  assign is_wr    = drain_s.data[serial_cfg_pkg::WRITE_BIT];
  assign cmd_addr = {1'b0, drain_s.data[serial_cfg_pkg::ADDR_MSB:
                                        serial_cfg_pkg::ADDR_LSB]};
  assign cmd_data = drain_s.data[7:0];

  always_comb begin
    next_state = state;
    case (state)
      CMD_IDLE: begin
        if (take && !is_wr) begin
          next_state = CMD_WAIT;
        end
      end
      CMD_WAIT: begin
        if (rsp_a2 == rsp_tgl) begin
          next_state = CMD_IDLE;
        end
      end
      default: begin
        next_state = CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (por) begin
      state <= CMD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // register images; only named fields exist, the rest reads zero
  always_comb begin
    in_img = '0;
    in_img[serial_cfg_pkg::IN_SEL_LSB +: 2] = in_sel;
  end

  always_comb begin
    out_img = '0;
    out_img[serial_cfg_pkg::OUT_MODE_LSB +: 2] = out_mode;
    out_img[serial_cfg_pkg::SRC_CLK_BIT]       = src_clk;
    out_img[serial_cfg_pkg::SEC_CFG_LSB +: 2]  = sec_cfg;
    out_img[serial_cfg_pkg::GP_LEVEL_BIT]      = gp_level;
  end

  assign in_new  = put_byte(in_img, cmd_addr[1:0], cmd_data);
  assign out_new = put_byte(out_img, cmd_addr[1:0], cmd_data);
  assign wr_in   = take && is_wr && hit(cmd_addr,
                   serial_cfg_pkg::IN_CTL_ADDR);
  assign wr_out  = take && is_wr && hit(cmd_addr,
                   serial_cfg_pkg::OUT_CTL_ADDR);

  // fields kept through an application reset
  always_ff @(posedge core_clk) begin
    if (por) begin
      in_sel   <= serial_cfg_pkg::SEL_RST;
      out_mode <= serial_cfg_pkg::MODE_RST;
      src_clk  <= serial_cfg_pkg::SRC_RST;
    end else begin
      if (wr_in) begin
        in_sel <= in_new[serial_cfg_pkg::IN_SEL_LSB +: 2];
      end
      if (wr_out) begin
        out_mode <= out_new[serial_cfg_pkg::OUT_MODE_LSB +: 2];
        src_clk  <= out_new[serial_cfg_pkg::SRC_CLK_BIT];
      end
    end
  end

  // fields cleared by any reset
  always_ff @(posedge core_clk) begin
    if (por || app_rst) begin
      sec_cfg  <= serial_cfg_pkg::SEC_RST;
      gp_level <= serial_cfg_pkg::GP_RST;
    end else if (wr_out) begin
      sec_cfg  <= out_new[serial_cfg_pkg::SEC_CFG_LSB +: 2];
      gp_level <= out_new[serial_cfg_pkg::GP_LEVEL_BIT];
    end
  end

  // read answer, handed to the transmit side by toggle
  always_ff @(posedge core_clk) begin
    if (por) begin
      rd_data <= 8'h00;
      rsp_tgl <= 1'b0;
    end else if (take && !is_wr) begin
      rsp_tgl <= ~rsp_tgl;
      if (hit(cmd_addr, serial_cfg_pkg::IN_CTL_ADDR)) begin
        rd_data <= get_byte(in_img, cmd_addr[1:0]);
      end else if (hit(cmd_addr, serial_cfg_pkg::OUT_CTL_ADDR)) begin
        rd_data <= get_byte(out_img, cmd_addr[1:0]);
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (por) begin
      rsp_a1 <= 1'b0;
      rsp_a2 <= 1'b0;
    end else begin
      rsp_a1 <= rsp_seen;
      rsp_a2 <= rsp_a1;
    end
  end

  // transmit clock: spi opposite edge, or source synchronous clock
  assign src_sync = out_mode == serial_cfg_pkg::OUT_MODE_SRCSYNC;
  assign tx_clk   = src_sync ? (src_clk ? osc_clk : sclk)
                             : ~samp_clk;
  assign dual     = sec_cfg == serial_cfg_pkg::SEC_DUAL;
  assign skip     = in_sel[0] && !src_sync;

  always_ff @(posedge tx_clk or negedge link_run) begin
    if (!link_run) begin
      cfg_t1   <= 2'h0;
      cfg_t2   <= 2'h0;
      rsp_t1   <= 1'b0;
      rsp_t2   <= 1'b0;
      rsp_seen <= 1'b0;
      tx_hold  <= 8'h00;
    end else begin
      cfg_t1 <= {dual, skip};
      cfg_t2 <= cfg_t1;
      rsp_t1 <= rsp_tgl;
      rsp_t2 <= rsp_t1;
      if (!tx_live && rsp_t2 != rsp_seen) begin
        tx_hold  <= rd_data;
        rsp_seen <= rsp_t2;
      end
    end
  end

  assign idx  = tx_cnt + 5'h01;
  assign pos0 = cfg_t2[1] ? {idx, 1'b0} : {1'b0, idx};
  assign pos1 = pos0 + 6'h01;

  always_ff @(posedge tx_clk or posedge cs_b) begin
    if (cs_b) begin
      tx_cnt  <= 5'h00;
      tx_live <= 1'b0;
      out0    <= 1'b0;
      out1    <= 1'b0;
    end else if (!tx_live && cfg_t2[0]) begin
      tx_live <= 1'b1;
    end else begin
      tx_live <= 1'b1;
      tx_cnt  <= tx_cnt + 5'h01;
      out0    <= pick({8'h00, tx_hold}, pos0);
      out1    <= pick({8'h00, tx_hold}, pos1);
    end
  end

  // pins
  assign first_serial_output      = out0;
  assign first_serial_output_oe_b = cs_b;
  assign srcsync_clk_out          = (src_sync && !cs_b) ? tx_clk : 1'b0;
  assign clock_polarity           = in_sel[1];
  assign clock_phase              = in_sel[0];

  always_comb begin
    second_serial_output      = 1'b0;
    second_serial_output_oe_b = 1'b1;
    case (sec_cfg)
      serial_cfg_pkg::SEC_TRISTATE: begin
        second_serial_output_oe_b = 1'b1;
      end
      serial_cfg_pkg::SEC_ALARM: begin
        second_serial_output      = alarm_in;
        second_serial_output_oe_b = 1'b0;
      end
      serial_cfg_pkg::SEC_GPO: begin
        second_serial_output      = gp_level;
        second_serial_output_oe_b = 1'b0;
      end
      serial_cfg_pkg::SEC_DUAL: begin
        second_serial_output      = out1;
        second_serial_output_oe_b = cs_b;
      end
      default: begin
        second_serial_output_oe_b = 1'b1;
      end
    endcase
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (por);

  sequence s_rd(logic [7:0] a);
    take && !is_wr && cmd_addr == a;
  endsequence

  sequence s_wr(logic [7:0] a);
    take && is_wr && cmd_addr == a;
  endsequence

  a_in_sel_read: assert property (
    s_rd(serial_cfg_pkg::IN_CTL_ADDR) |=> rd_data == {6'h00, $past(in_sel)})
    else $error("input select read back wrong");

  a_in_upper_zero: assert property (
    s_rd(serial_cfg_pkg::IN_CTL_ADDR + 8'h01) |=> rd_data == 8'h00)
    else $error("input register upper byte not zero");

  a_out_low_read: assert property (
    s_rd(serial_cfg_pkg::OUT_CTL_ADDR) |=>
      rd_data[7] == 1'b0 && rd_data[5:2] == 4'h0)
    else $error("output register reserved bits not zero");

  a_out_high_read: assert property (
    s_rd(serial_cfg_pkg::OUT_CTL_ADDR + 8'h01) |=>
      rd_data == {3'h0, $past(gp_level), 2'h0, $past(sec_cfg)})
    else $error("output register byte one read back wrong");

  a_in_sel_write: assert property (
    s_wr(serial_cfg_pkg::IN_CTL_ADDR) |=> in_sel == $past(cmd_data[1:0])
      && clock_phase == $past(cmd_data[0]))
    else $error("input select write lost");

  a_gp_level_write: assert property (
    s_wr(serial_cfg_pkg::OUT_CTL_ADDR + 8'h01) |=>
      gp_level == $past(cmd_data[4]) ##1 gp_level == $past(gp_level))
    else $error("gp level write lost");

  a_tristate_pin: assert property (
    sec_cfg == serial_cfg_pkg::SEC_TRISTATE |-> second_serial_output_oe_b)
    else $error("second pin driven while tri-state");

  a_alarm_pin: assert property (
    sec_cfg == serial_cfg_pkg::SEC_ALARM |->
      !second_serial_output_oe_b && second_serial_output == alarm_in)
    else $error("alarm not on second pin");

  a_gp_pin_level: assert property (
    sec_cfg == serial_cfg_pkg::SEC_GPO |->
      !second_serial_output_oe_b && second_serial_output == gp_level)
    else $error("gp level not on second pin");

  a_srcsync_idle: assert property (
    !src_sync |-> srcsync_clk_out == 1'b0)
    else $error("source sync clock outside its mode");

  a_app_keep: assert property (
    app_rst |=> in_sel == $past(in_sel) && out_mode == $past(out_mode)
      && sec_cfg == 2'h0 && !gp_level)
    else $error("application reset cleared wrong fields");

  a_read_wait: assert property (
    s_rd(serial_cfg_pkg::IN_CTL_ADDR) |=> !drain_s.ready [*2])
    else $error("drain not stalled during read answer");
endmodule : serial_port_protocol_config
`default_nettype wire

// [logic/stream_if.sv]
// valid/ready word stream between the link side and the register file
// assumes one clock domain on both modports
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(
  parameter int WIDTH = 16
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// [tb/host_spi.sv]
// host spi controller model: drives 16-bit frames, captures the answer
// assumes the device answers a read two frames after the read frame
`timescale 1ns/100ps
`default_nettype none
module host_spi #(
  parameter real HALF = 15.0
) (
  output logic      sclk,
  output logic      cs_b,
  output logic      serial_in,
  input  wire logic sdo0,
  input  wire logic sdo1
);
  initial begin
    sclk      = 1'b0;
    cs_b      = 1'b1;
    serial_in = 1'b1;
  end
  // lane 0 carries odd bits, lane 1 even bits in two-lane mode
  task automatic capture(input logic dual, input int k,
                         inout logic [15:0] rx);
    int j;
    j = 15 - k;
    if (!dual) begin
      rx[k] = sdo0;
    end else if (j < 8) begin
      rx[15-2*j] = sdo0;
      rx[14-2*j] = sdo1;
    end
  endtask : capture
  // idle level is polarity; phase picks first or second edge to sample
  task automatic xfer(input logic [1:0] mode, input logic dual,
                      input logic [15:0] tx, output logic [15:0] rx);
    int k;
    rx = 16'h0000;
    sclk = mode[1];
    #(HALF);
    cs_b = 1'b0;
    // phase 1 changes data on the leading edge, away from the sampling edge
    for (k = 15; k >= 0; k--) begin
      if (!mode[0]) serial_in = tx[k];
      #(HALF);
      sclk = ~sclk;
      if (mode[0]) serial_in = tx[k];
      else capture(dual, k, rx);
      #(HALF);
      sclk = ~sclk;
      if (mode[0]) capture(dual, k, rx);
    end
    #(HALF);
    cs_b = 1'b1;
    // released line shows the inverse of its last value
    serial_in = ~serial_in;
    #(2*HALF);
  endtask : xfer
endmodule : host_spi
`default_nettype wire

// [tb/serial_port_protocol_config_tb.sv]
// testbench: register access over the host link, pin functions, resets
// assumes host_spi as the far side and the design's frame format
`timescale 1ns/100ps
`default_nettype none
module serial_port_protocol_config_tb;
  logic        core_clk = 1'b0;
  logic        osc_clk  = 1'b0;
  logic        rst_b, app_rst_b, rsel, alarm_in;
  logic        sclk, cs_b, serial_in;
  logic        sdo0, sdo0_oe_b, sdo1, sdo1_oe_b;
  logic        srcsync_clk_out, clock_polarity, clock_phase;
  wire logic   sdo0_w, sdo1_w;
  int          checks, n_fail, cycles, i;
  logic [1:0]  hmode;
  logic        hdual;
  logic [7:0]  a, v;
  logic [7:0]  tab [5] = '{8'h00, 8'h11, 8'h12, 8'h02, 8'h13};

  assign sdo0_w = sdo0_oe_b ? 1'bz : sdo0;
  assign sdo1_w = sdo1_oe_b ? 1'bz : sdo1;
  always #5 core_clk = ~core_clk;
  always #4 osc_clk = ~osc_clk;

  serial_port_protocol_config serial_port_protocol_config_inst (
    .core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .osc_clk(osc_clk),
    .cs_b(cs_b), .serial_in(serial_in), .app_rst_b(app_rst_b),
    .reset_pin_app_select(rsel), .alarm_in(alarm_in),
    .first_serial_output(sdo0), .first_serial_output_oe_b(sdo0_oe_b),
    .second_serial_output(sdo1), .second_serial_output_oe_b(sdo1_oe_b),
    .srcsync_clk_out(srcsync_clk_out), .clock_polarity(clock_polarity),
    .clock_phase(clock_phase));
  host_spi host_spi_inst (
    .sclk(sclk), .cs_b(cs_b), .serial_in(serial_in),
    .sdo0(sdo0_w), .sdo1(sdo1_w));

  task automatic final_report();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [15:0] rx;
    host_spi_inst.xfer(hmode, hdual, {1'b1, ad[6:0], d}, rx);
    repeat (10) @(posedge core_clk);
  endtask : wr
  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
    logic [15:0] rx;
    host_spi_inst.xfer(hmode, hdual, {1'b0, ad[6:0], 8'h00}, rx);
    repeat (10) @(posedge core_clk);
    // answer is loaded at the start of the second frame after the read
    repeat (2) begin
      host_spi_inst.xfer(hmode, hdual, {1'b1, 7'h7f, 8'h00}, rx);
      repeat (10) @(posedge core_clk);
    end
    check($sformatf("reg %h", ad), rx, {8'h00, e});
  endtask : rdchk
  // sel 0: held low, 1: follows sclk, 2: follows osc_clk
  task automatic srcmon(input logic [1:0] sel);
    fork
      wr(8'h7f, 8'h00);
      begin
        #(37.5);
        repeat (8) begin
          check("srcsync clk", srcsync_clk_out, sel == 2'd0 ? 1'b0 :
                sel == 2'd1 ? sclk : osc_clk);
          #(11);
        end
      end
    join
  endtask : srcmon
  task automatic app_pulse();
    @(posedge core_clk) app_rst_b <= 1'b0;
    repeat (5) @(posedge core_clk);
    app_rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : app_pulse

  initial begin
    rst_b = 1'b0;
    app_rst_b = 1'b1;
    rsel = 1'b0;
    alarm_in = 1'b0;
    checks = 0;
    n_fail = 0;
    cycles = 0;
    hmode = 2'd0;
    hdual = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (a = 8'h08; a <= 8'h0f; a++) rdchk(a, 8'h00);
    check("sec oe_b", sdo1_oe_b, 1'b1);
    for (a = 8'h09; a <= 8'h0b; a++) begin
      wr(a, 8'hff);
      rdchk(a, 8'h00);
    end
    for (a = 8'h0e; a <= 8'h0f; a++) begin
      wr(a, 8'hff);
      rdchk(a, 8'h00);
    end
    wr(8'h20, 8'h5a);
    rdchk(8'h20, 8'h00);
    wr(8'h0c, 8'hbc);
    rdchk(8'h0c, 8'h00);
    wr(8'h0c, 8'h41);
    rdchk(8'h0c, 8'h41);
    srcmon(2'd0);
    wr(8'h0d, 8'hff);
    hdual = 1'b1;
    rdchk(8'h0d, 8'h13);
    for (i = 0; i < 5; i++) begin
      v = tab[i];
      wr(8'h0d, v);
      hdual = (v[1:0] == 2'd3);
      rdchk(8'h0d, v);
      check("sec oe_b", sdo1_oe_b, v[1:0] == 2'd1 || v[1:0] == 2'd2 ?
            1'b0 : 1'b1);
      if (v[1:0] == 2'd2) check("gp level", sdo1, v[4]);
      if (v[1:0] == 2'd1) begin
        @(posedge core_clk) alarm_in <= 1'b1;
        @(posedge core_clk) #1 check("alarm", sdo1, 1'b1);
        @(posedge core_clk) alarm_in <= 1'b0;
        @(posedge core_clk) #1 check("alarm", sdo1, 1'b0);
      end
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h08, 8'hfc | i[7:0]);
      hmode = i[1:0];
      wr(8'h7f, 8'h00);
      rdchk(8'h08, i[7:0]);
      check("polarity", clock_polarity, i[1]);
      check("phase", clock_phase, i[0]);
    end
    wr(8'h0c, 8'h03);
    srcmon(2'd1);
    wr(8'h0c, 8'h43);
    srcmon(2'd2);
    wr(8'h0c, 8'h01);
    check("srcsync idle", srcsync_clk_out, 1'b0);
    @(posedge core_clk) rsel <= 1'b1;
    app_pulse();
    hdual = 1'b0;
    rdchk(8'h08, 8'h03);
    rdchk(8'h0c, 8'h01);
    rdchk(8'h0d, 8'h00);
    wr(8'h0d, 8'h13);
    @(posedge core_clk) rsel <= 1'b0;
    app_pulse();
    hmode = 2'd0;
    rdchk(8'h08, 8'h00);
    rdchk(8'h0c, 8'h00);
    rdchk(8'h0d, 8'h00);
    check("sec oe_b", sdo1_oe_b, 1'b1);
    final_report();
  end
endmodule : serial_port_protocol_config_tb
`default_nettype wire
